/* File: lbc_defines.vh */
// Constants for the local bus cycle signalling block
`ifndef LBC_DEFINES_VH
`define LBC_DEFINES_VH
// Clock and bus state timing
`define LBC_CLK_PERIOD_NS   100
`define LBC_CLK_DIV         2
// Byte lane encodings {upper_byte_enable_n, a0}
`define LBC_LANE_WORD       2'h0
`define LBC_LANE_UPPER      2'h1
`define LBC_LANE_LOWER      2'h2
`define LBC_LANE_REFRESH    2'h3
// Cycle status codes, active low
`define LBC_ST_INTA         3'h0
`define LBC_ST_IORD         3'h1
`define LBC_ST_IOWR         3'h2
`define LBC_ST_HALT         3'h3
`define LBC_ST_FETCH        3'h4
`define LBC_ST_MEMRD        3'h5
`define LBC_ST_MEMWR        3'h6
`define LBC_ST_PASSIVE      3'h7
// Status code field positions
`define LBC_ST_WRITE_BIT    1
`define LBC_ST_MEM_BIT      2
`endif

/* File: lbc_sync.v */
// Two-flop synchroniser for a vector of level inputs
`timescale 1ns/1ps
module lbc_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             reset,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            stage1   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // lbc_sync

/* File: lbc_bus_cycle.v */
// Local bus cycle sequencer and pin driver
`timescale 1ns/1ps
`include "lbc_defines.vh"

// Functional notes
// - Drive address bits 19-16 on upper pins during first state.
// - Later states: origin flag low for processor cycle, high for transfer engine.
// - Later states: other three upper status bits held low.
// - Float bus, byte enable, transceiver enable and direction during hold or reset.
// - Narrow variant keeps middle address byte valid first through fourth state.
// - Shared bus carries address in first state, data afterwards.
// - Wide variant: lowest address bit low in first state for lower-lane byte moves.
// - Wide variant: upper byte enable driven from lane code in first state through third and wait states.
// - Lane encoding: word, upper, lower, refresh with both high.
// - Address strobe high in first state; address valid at falling edge.
// - Asynchronous ready rising edge accepted; responder times falling edge.
// - Output clock 50% duty, running through reset and hold.
// - Transceiver enable low during accesses, high when direction changes.
// - Transfer requests are level inputs, synchronised internally.
// - Direction low for incoming data, high for outgoing write data.
// - Grant raised with bus float on request; dropped when request low.
// - Active-low cycle status outputs encode type; float during grant.
module lbc_bus_cycle (
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset,
    // Variant and mode straps
    input  wire        narrow_variant,
    input  wire        enhanced_mode,
    // Internal cycle request
    input  wire        cyc_req,
    input  wire [2:0]  cyc_type,
    input  wire        cyc_dma,
    input  wire        cyc_refresh,
    input  wire [19:0] cyc_addr,
    input  wire [1:0]  cyc_size,
    input  wire [15:0] cyc_wdata,
    output reg         cyc_done,
    output reg  [15:0] cyc_rdata,
    // Ready and requests
    input  wire        async_ready_in,
    input  wire        sync_ready_in,
    input  wire [1:0]  transfer_request_in,
    output reg  [1:0]  transfer_request_sync,
    input  wire        bus_request_in,
    output reg         bus_grant_out,
    // Clock out
    output reg         system_clock_out,
    // Upper address/status and middle address pins
    output reg  [3:0]  upper_addr_status_pins,
    output reg         upper_addr_status_oe,
    output reg  [7:0]  middle_addr_outputs,
    output reg         middle_addr_oe,
    // Shared address/data bus
    input  wire [15:0] muxed_addr_data_bus_in,
    output reg  [15:0] muxed_addr_data_bus_out,
    output reg         muxed_addr_data_bus_oe,
    // Control pins
    output reg         upper_byte_enable_n,
    output reg         upper_byte_enable_oe,
    output reg         addr_strobe,
    output reg         xcvr_enable_n,
    output reg         xcvr_enable_oe,
    output reg         xfer_direction,
    output reg         xfer_direction_oe,
    output reg  [2:0]  cycle_status_code,
    output reg         cycle_status_oe
);
    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_T1   = 7'h02;
    localparam [6:0] ST_T2   = 7'h04;
    localparam [6:0] ST_T3   = 7'h08;
    localparam [6:0] ST_TW   = 7'h10;
    localparam [6:0] ST_T4   = 7'h20;
    localparam [6:0] ST_HOLD = 7'h40;

    reg [6:0]  state;
    reg [6:0]  next_state;
    reg        phase;
    reg [19:0] addr;
    reg [15:0] wdata;
    reg [2:0]  ctype;
    reg        dma;
    reg [1:0]  lanes;
    reg        ready_seen;
    reg        async_ready_in_meta;
    reg        async_ready_in_sync;
    reg        req_meta;
    reg        req_sync;
    reg [1:0]  drq_sync;

    // Write cycles are memory or I/O writes
    function is_write;
        input [2:0] code;
        begin
            is_write = (code == `LBC_ST_IOWR) || (code == `LBC_ST_MEMWR);
        end
    endfunction

    // Cycles that move data through the transceivers
    function is_access;
        input [2:0] code;
        begin
            is_access = (code != `LBC_ST_HALT) && (code != `LBC_ST_PASSIVE);
        end
    endfunction

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    lbc_sync #(.WIDTH(2)) u_drq_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (transfer_request_in),
        .sync_out (drq_sync)
    );

    // Ready rising edge may be asynchronous, so it goes through two flops
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            async_ready_in_meta <= 1'b0;
            async_ready_in_sync <= 1'b0;
            req_meta  <= 1'b0;
            req_sync  <= 1'b0;
            transfer_request_sync <= 2'h0;
        end else begin
            async_ready_in_meta <= async_ready_in;
            async_ready_in_sync <= async_ready_in_meta;
            req_meta  <= bus_request_in;
            req_sync  <= req_meta;
            transfer_request_sync <= drq_sync;
        end
    end

    // ------------------------------------------------------------------
    // Clock output and state machine
    // ------------------------------------------------------------------
    // One bus state is two core clocks; phase 1 is the last half
    wire state_end = phase;

    // No reset here: the output clock has to keep running through reset
    always @(posedge core_clk) begin
        if (phase) begin
            phase            <= 1'b0;
            system_clock_out <= 1'b0;
        end else begin
            phase            <= 1'b1;
            system_clock_out <= 1'b1;
        end
    end

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (req_sync)
                    next_state = ST_HOLD;
                else if (cyc_req)
                    next_state = ST_T1;
            end
            ST_T1:   next_state = ST_T2;
            ST_T2:   next_state = ST_T3;
            ST_T3:   next_state = ready_seen ? ST_T4 : ST_TW;
            ST_TW:   next_state = ready_seen ? ST_T4 : ST_TW;
            ST_T4:   next_state = req_sync ? ST_HOLD : ST_IDLE;
            ST_HOLD: next_state = req_sync ? ST_HOLD : ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state            <= ST_IDLE;
            ready_seen       <= 1'b0;
            addr             <= 20'h0_0000;
            wdata            <= 16'h0000;
            ctype            <= `LBC_ST_PASSIVE;
            dma              <= 1'b0;
            lanes            <= `LBC_LANE_WORD;
            cyc_done         <= 1'b0;
            cyc_rdata        <= 16'h0000;
        end else begin
            cyc_done         <= 1'b0;
            // Ready sampled once per output clock, mid-period
            if (!phase)
                ready_seen <= async_ready_in_sync | sync_ready_in;
            if (state_end) begin
                state <= next_state;
                if (state == ST_IDLE && next_state == ST_T1) begin
                    addr  <= cyc_addr;
                    wdata <= cyc_wdata;
                    ctype <= cyc_type;
                    dma   <= cyc_dma;
                    if (enhanced_mode && cyc_refresh)
                        lanes <= `LBC_LANE_REFRESH;
                    else
                        lanes <= cyc_size;
                end
                if (state == ST_T4) begin
                    cyc_done  <= 1'b1;
                    cyc_rdata <= muxed_addr_data_bus_in;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin drive, registered
    // ------------------------------------------------------------------
    wire in_cycle = (state == ST_T1) || (state == ST_T2) || (state == ST_T3) ||
                    (state == ST_TW) || (state == ST_T4);
    wire late     = in_cycle && (state != ST_T1);
    wire drive    = (state != ST_HOLD);
    wire wr       = is_write(ctype);

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            upper_addr_status_pins  <= 4'h0;
            upper_addr_status_oe    <= 1'b0;
            middle_addr_outputs     <= 8'h00;
            middle_addr_oe          <= 1'b0;
            muxed_addr_data_bus_out <= 16'h0000;
            muxed_addr_data_bus_oe  <= 1'b0;
            upper_byte_enable_n     <= 1'b1;
            upper_byte_enable_oe    <= 1'b0;
            addr_strobe             <= 1'b0;
            xcvr_enable_n           <= 1'b1;
            xcvr_enable_oe          <= 1'b0;
            xfer_direction          <= 1'b0;
            xfer_direction_oe       <= 1'b0;
            cycle_status_code       <= `LBC_ST_PASSIVE;
            cycle_status_oe         <= 1'b0;
            bus_grant_out           <= 1'b0;
        end else begin
            bus_grant_out          <= (state == ST_HOLD);
            upper_addr_status_oe   <= drive;
            middle_addr_oe         <= drive && narrow_variant;
            upper_byte_enable_oe   <= drive && !narrow_variant;
            xcvr_enable_oe         <= drive;
            xfer_direction_oe      <= drive;
            cycle_status_oe        <= drive;
            cycle_status_code      <= in_cycle && state != ST_T4 ? ctype : `LBC_ST_PASSIVE;
            addr_strobe            <= (state == ST_T1) && !phase;
            if (state == ST_T1)
                upper_addr_status_pins <= addr[19:16];
            else if (late)
                upper_addr_status_pins <= {dma, 3'b000};
            if (in_cycle)
                middle_addr_outputs <= addr[15:8];
            if (state == ST_T1) begin
                muxed_addr_data_bus_oe  <= 1'b1;
                muxed_addr_data_bus_out <= narrow_variant ? {8'h00, addr[7:0]}
                                                          : {addr[15:1], lanes[0]};
            end else if (late && wr) begin
                muxed_addr_data_bus_oe  <= 1'b1;
                muxed_addr_data_bus_out <= wdata;
            end else begin
                muxed_addr_data_bus_oe  <= 1'b0;
            end
            // Enable driven from the lane code upper bit from first state through third and wait states
            if (state == ST_T1 || state == ST_T2 || state == ST_T3 || state == ST_TW)
                upper_byte_enable_n <= lanes[1];
            else
                upper_byte_enable_n <= 1'b1;
            // Direction only moves while the transceiver is disabled
            if (state == ST_T1) begin
                xcvr_enable_n  <= 1'b1;
                xfer_direction <= wr;
            end else if (late && state != ST_T4 && is_access(ctype)) begin
                xcvr_enable_n  <= 1'b0;
            end else begin
                xcvr_enable_n  <= 1'b1;
            end
        end
    end
endmodule // lbc_bus_cycle

/* File: lbc_bus_cycle_chk.sv */
// Concurrent checks on the local bus cycle pins
`timescale 1ns/1ps
`include "lbc_defines.vh"
module lbc_bus_cycle_chk (
    // Clock, reset and straps
    input wire logic        core_clk, reset, narrow_variant, enhanced_mode,
    // Cycle request and handshakes
    input wire logic [2:0]  cyc_type,
    input wire logic        cyc_dma, cyc_refresh, cyc_done, bus_request_in, bus_grant_out, system_clock_out,
    input wire logic [19:0] cyc_addr,
    input wire logic [1:0]  cyc_size,
    // Bus pins
    input wire logic [3:0]  upper_addr_status_pins,
    input wire logic [7:0]  middle_addr_outputs,
    input wire logic [15:0] muxed_addr_data_bus_out,
    input wire logic [2:0]  cycle_status_code,
    input wire logic        upper_addr_status_oe, muxed_addr_data_bus_oe, upper_byte_enable_n, upper_byte_enable_oe,
    input wire logic        addr_strobe, xcvr_enable_n, xcvr_enable_oe, xfer_direction, xfer_direction_oe,
    input wire logic        cycle_status_oe, middle_addr_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Data phase: transceiver enabled and driven
    wire data_phase = !xcvr_enable_n && xcvr_enable_oe;

    a_float_grant: assert property (bus_grant_out |-> !(upper_addr_status_oe | muxed_addr_data_bus_oe
        | upper_byte_enable_oe | xcvr_enable_oe | xfer_direction_oe | middle_addr_oe))
        else $error("bus driven in grant");
    a_status_float: assert property (bus_grant_out |-> !cycle_status_oe) else $error("status driven");
    a_addr_phase: assert property (addr_strobe |-> upper_addr_status_oe && upper_addr_status_pins == cyc_addr[19:16]
        && (narrow_variant ? muxed_addr_data_bus_out[7:1] == cyc_addr[7:1]
            : muxed_addr_data_bus_out[15:1] == cyc_addr[15:1])) else $error("bad address phase");
    a_lane_code: assert property (addr_strobe && !narrow_variant |-> {upper_byte_enable_n, muxed_addr_data_bus_out[0]}
        == (cyc_refresh && enhanced_mode ? 2'h3 : cyc_size)) else $error("bad lane code");
    a_later_status: assert property (data_phase |-> upper_addr_status_pins == {cyc_dma, 3'h0})
        else $error("bad later status");
    a_status_code: assert property (addr_strobe |-> cycle_status_oe && cycle_status_code == cyc_type)
        else $error("bad cycle status");
    a_clock_half: assert property (!$past(reset) |-> system_clock_out != $past(system_clock_out))
        else $error("clock out stalled");
    a_den_on_turn: assert property (xfer_direction_oe && $past(xfer_direction_oe) && $changed(xfer_direction)
        |-> xcvr_enable_n) else $error("transceiver on at turn");
    a_strobe_valid: assert property ($fell(addr_strobe) |-> muxed_addr_data_bus_oe
        && $stable(muxed_addr_data_bus_out)) else $error("address moved at strobe fall");
    a_done_spacing: assert property ($rose(addr_strobe) |-> !cyc_done [*7]) else $error("cycle too short");
    a_grant_drop: assert property (!bus_request_in |-> ##[0:8] !bus_grant_out) else $error("grant held");
    a_dir_write: assert property (data_phase |-> xfer_direction
        == (cyc_type == `LBC_ST_IOWR || cyc_type == `LBC_ST_MEMWR)) else $error("bad direction");
    a_middle_addr: assert property (narrow_variant && (addr_strobe || data_phase) |-> middle_addr_oe
        && middle_addr_outputs == cyc_addr[15:8]) else $error("bad middle address");

    c_grant: cover property ($rose(bus_grant_out));
    c_dma_cycle: cover property ($rose(addr_strobe) && cyc_dma);
    c_refresh: cover property (cyc_done && cyc_refresh);
    c_narrow: cover property (addr_strobe && narrow_variant);
endmodule // lbc_bus_cycle_chk

/* File: lbc_far_end.sv */
// Far-side memory and peripheral model for the local bus
`timescale 1ns/1ps
module lbc_far_end (
    // Pins from the block
    input wire logic        core_clk,
    input wire logic [15:0] muxed_addr_data_bus_out,
    input wire logic        muxed_addr_data_bus_oe, addr_strobe, xcvr_enable_n, xfer_direction,
    // Wait states; 15 leaves completion to the sync input
    input wire logic [3:0]  far_waits,
    // Back to the block
    output logic [15:0]     muxed_addr_data_bus_in,
    output logic            async_ready_in,
    output logic [15:0]     last_wr
);
    logic [15:0] addr = 16'h0000;
    logic [1:0]  idle = 2'h3;
    int          cnt = 0;
    initial begin
        muxed_addr_data_bus_in = 16'h0000;
        async_ready_in = 1'b0;
        last_wr = 16'h0000;
    end
    always @(negedge addr_strobe) addr = muxed_addr_data_bus_out;
    always @(posedge core_clk) begin
        idle <= {idle[0], xcvr_enable_n};
        if (xcvr_enable_n) begin
            cnt = 0;
            async_ready_in <= 1'b0;
        end else begin
            cnt++;
            // Rise lands 23 ns after the clock edge so it is never aligned to the clock
            if (cnt == far_waits + 1) async_ready_in <= #23 1'b1;
        end
        if (!xcvr_enable_n && xfer_direction && muxed_addr_data_bus_oe) last_wr <= muxed_addr_data_bus_out;
        if (!xcvr_enable_n && !xfer_direction) muxed_addr_data_bus_in <= addr ^ 16'hA5A5;
        // Bus released for two clocks, or turned for a write, shows a changing pattern instead of stale data
        else if (&idle || xfer_direction) muxed_addr_data_bus_in <= ~muxed_addr_data_bus_in;
    end
endmodule // lbc_far_end

/* File: tb_top.sv */
// Self-checking bench for the local bus cycle block
`timescale 1ns/1ps
`include "lbc_defines.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module tb_top;
    typedef struct {logic [2:0] t; logic d, rf; logic [19:0] a; logic [1:0] s; logic [15:0] w; logic [3:0] ws;
                    logic [15:0] e; logic [1:0] k;} lbc_row_t;
    logic        core_clk = 0, reset = 1, narrow_variant = 0, enhanced_mode = 1, cyc_req = 0, cyc_dma = 0;
    logic        cyc_refresh = 0, sync_ready_in = 0, bus_request_in = 0, async_ready_in, cyc_done, bus_grant_out;
    logic        system_clock_out, addr_strobe, upper_addr_status_oe, middle_addr_oe, muxed_addr_data_bus_oe;
    logic        upper_byte_enable_n, upper_byte_enable_oe, xcvr_enable_n, xcvr_enable_oe, xfer_direction;
    logic        xfer_direction_oe, cycle_status_oe;
    logic [1:0]  cyc_size = 0, transfer_request_in = 0, transfer_request_sync;
    logic [2:0]  cyc_type = 0, cycle_status_code;
    logic [3:0]  far_waits = 0, upper_addr_status_pins;
    logic [7:0]  middle_addr_outputs;
    logic [15:0] cyc_wdata = 0, cyc_rdata, muxed_addr_data_bus_in, muxed_addr_data_bus_out, last_wr;
    logic [19:0] cyc_addr = 0;
    int          fails = 0, checks = 0, ticks = 0;
    wire  [5:0]  oes = {upper_addr_status_oe, muxed_addr_data_bus_oe, upper_byte_enable_oe, xcvr_enable_oe,
                        xfer_direction_oe, cycle_status_oe};
    // Type, dma, refresh, address, lanes, write data, waits, expected data, kind (1 read, 2 write)
    lbc_row_t rows[8] = '{
        '{`LBC_ST_MEMRD, 0, 0, 20'hA_1234, 2'h0, 16'h0000, 4'h0, 16'hB791, 2'h1},
        '{`LBC_ST_MEMWR, 1, 0, 20'h5_0F02, 2'h2, 16'hBEEF, 4'h2, 16'hBEEF, 2'h2},
        '{`LBC_ST_IORD,  0, 0, 20'h0_00F0, 2'h0, 16'h0000, 4'hF, 16'hA555, 2'h1},
        '{`LBC_ST_IOWR,  0, 0, 20'h0_0081, 2'h1, 16'h1234, 4'h1, 16'h1234, 2'h2},
        '{`LBC_ST_FETCH, 1, 0, 20'hF_FFF0, 2'h0, 16'h0000, 4'h3, 16'h5A55, 2'h1},
        '{`LBC_ST_INTA,  0, 0, 20'h0_0000, 2'h0, 16'h0000, 4'h0, 16'h0000, 2'h0},
        '{`LBC_ST_HALT,  0, 0, 20'h0_0002, 2'h0, 16'h0000, 4'hF, 16'h0000, 2'h0},
        '{`LBC_ST_MEMRD, 0, 1, 20'h0_0100, 2'h0, 16'h0000, 4'h0, 16'h0000, 2'h0}};

    lbc_bus_cycle DUT (.*);
    lbc_far_end far (.*);

    always #50 core_clk = ~core_clk;

    task automatic close_out;
        $display("Checks %0d, errors %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic run_row(input lbc_row_t r);
        int n;
        logic [15:0] m;
        m = {{8{~r.s[1]}}, {8{~r.s[0]}}};
        @(posedge core_clk);
        {cyc_req, cyc_type, cyc_dma, cyc_refresh, cyc_addr, cyc_size, cyc_wdata} <= {1'b1, r.t, r.d, r.rf, r.a, r.s, r.w};
        far_waits <= r.ws;
        sync_ready_in <= (r.ws == 4'hF);
        for (n = 0; n < 100 && cyc_done !== 1'b1; n++) @(posedge core_clk) #1;
        `CHK(cyc_done, 1'b1)
        if (r.k == 2'h1) `CHK(cyc_rdata, r.e)
        if (r.k == 2'h2) `CHK(last_wr & m, r.e & m)
        @(posedge core_clk);
        cyc_req <= 1'b0;
        sync_ready_in <= 1'b0;
    endtask

    always @(posedge core_clk) begin
        ticks++;
        if (ticks == 5000) begin
            fails++;
            close_out;
        end
    end

    initial begin
        int n;
        logic c;
        repeat (10) @(posedge core_clk);
        `CHK(oes, 6'h00)
        reset <= 1'b0;
        foreach (rows[i]) run_row(rows[i]);
        @(posedge core_clk);
        transfer_request_in <= 2'h2;
        repeat (2) @(posedge core_clk);
        #1 `CHK(transfer_request_sync, 2'h0)
        @(posedge core_clk) #1;
        `CHK(transfer_request_sync, 2'h2)
        @(posedge core_clk);
        bus_request_in <= 1'b1;
        for (n = 0; n < 40 && bus_grant_out !== 1'b1; n++) @(posedge core_clk) #1;
        `CHK(bus_grant_out, 1'b1)
        `CHK(oes, 6'h00)
        @(posedge core_clk);
        bus_request_in <= 1'b0;
        for (n = 0; n < 40 && bus_grant_out !== 1'b0; n++) @(posedge core_clk) #1;
        `CHK(bus_grant_out, 1'b0)
        // Bus must be driven again after the hold ends
        run_row(rows[1]);
        // Narrow variant, then refresh with the enhanced mode off
        narrow_variant <= 1'b1;
        run_row(rows[3]);
        #1 `CHK(middle_addr_outputs, 8'h00)
        `CHK(middle_addr_oe, 1'b1)
        `CHK(upper_byte_enable_oe, 1'b0)
        @(posedge core_clk);
        narrow_variant <= 1'b0;
        enhanced_mode  <= 1'b0;
        run_row(rows[7]);
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 `CHK(oes, 6'h00)
        c = system_clock_out;
        @(posedge core_clk) #1;
        `CHK(system_clock_out, ~c)
        close_out;
    end
endmodule // tb_top

bind lbc_bus_cycle lbc_bus_cycle_chk u_chk (.*);
